// [core/aos_pkg.sv]
// Behaviour
// - Overflow sets sticky flag until branch/write.
// - No overflow leaves overflow flag untouched.
// - Negative flag copies result most significant bit on core operations, not on bus writes.
// - Six-bit counter counts only when mode zero.
// - Mode zero wraps, counts up/down per overflow.
// - Mode one loads saturation value on overflow.
// - Saturate instruction applies net counted overflow.
// - Listed shifts take count from multiplicand low nibble.
// - Loop flag high while repeat instructions execute.
package aos_pkg;

  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 8;
  localparam int          OVC_W        = 6;
  localparam int          MPC_W        = 16;
  localparam int          SHCNT_W      = 4;

  // Register byte offsets.
  localparam logic [7:0]  OFS_ST0      = 8'h00;
  localparam logic [7:0]  OFS_ST1      = 8'h04;
  localparam logic [7:0]  OFS_RESULT   = 8'h08;
  localparam logic [7:0]  OFS_MPC      = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_ST   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h14;

  // Status register zero field positions.
  localparam int          ST0_OVF_BIT  = 0;
  localparam int          ST0_NEG_BIT  = 1;
  localparam int          ST0_OVM_BIT  = 2;
  localparam int          ST0_OVC_LSB  = 8;
  // Status register one field positions.
  localparam int          ST1_LOOP_BIT = 0;

  // Interrupt status bits.
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_OVF_POS  = 0;
  localparam int          IRQ_OVF_NEG  = 1;
  localparam int          IRQ_SAT_DONE = 2;

  localparam logic [31:0] SAT_POS      = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_NEG      = 32'h80000000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    AOS_OP_NONE  = 3'h0,
    AOS_OP_ADD   = 3'h1,
    AOS_OP_SUB   = 3'h2,
    AOS_OP_SHIFT = 3'h3,
    AOS_OP_SAT   = 3'h4,
    AOS_OP_LOAD  = 3'h5
  } aos_op_e;

  typedef enum logic [1:0] {
    AOS_SH_ARITH_R = 2'h0,
    AOS_SH_LOGIC_L = 2'h1,
    AOS_SH_LOGIC_R = 2'h2,
    AOS_SH_RESULT_R = 2'h3
  } aos_shift_e;

  // One execute-stage command from the core.
  typedef struct packed {
    logic        valid;
    aos_op_e     op;
    aos_shift_e  shift;
    logic [31:0] operand;
  } aos_cmd_s;

  typedef struct packed {
    logic        loop_nz;
    logic        loop_z;
    logic        cond_branch;
    logic        mpc_load;
    logic [15:0] mpc_data;
  } aos_ctl_s;

endpackage

// [core/aos_sat_calc.sv]
`timescale 1ns/1ps
module aos_sat_calc
  import aos_pkg::*;
#(
  parameter int W = 32
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         sub,
  // Result
  output logic      [W-1:0] sum,
  output logic              ovf_pos,
  output logic              ovf_neg
);
  initial begin
    if (W < 2) $error("width too small");
  end

  logic [W-1:0] bb;

  always_comb begin
    bb      = sub ? ~b : b;
    sum     = a + bb + {{(W-1){1'b0}}, sub};
    // Signed overflow when both operand signs agree and differ from sum.
    ovf_pos = ~a[W-1] & ~bb[W-1] & sum[W-1];
    ovf_neg = a[W-1] & bb[W-1] & ~sum[W-1];
  end
endmodule

// [core/aos_shifter.sv]
`timescale 1ns/1ps
module aos_shifter
  import aos_pkg::*;
#(
  parameter int W  = 32,
  parameter int CW = 4
) (
  // Inputs
  input  wire logic [W-1:0]  value,
  input  wire logic [CW-1:0] count,
  input  wire aos_pkg::aos_shift_e kind,
  // Output
  output logic      [W-1:0]  result
);
  initial begin
    if (CW >= 6) $error("count width too large");
  end

  always_comb begin
    case (kind)
      AOS_SH_ARITH_R:  result = $signed(value) >>> count;
      AOS_SH_LOGIC_L:  result = value << count;
      AOS_SH_LOGIC_R:  result = value >> count;
      default:         result = $signed(value) >>> count;
    endcase
  end
endmodule

// [core/aos_top.sv]
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module aos_top
  import aos_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Core execute interface
  input  wire aos_pkg::aos_cmd_s   cmd,
  input  wire aos_pkg::aos_ctl_s   ctl,
  // Write address channel
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // Write data channel
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // Write response channel
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // Read address channel
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // Read data channel
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Status outputs
  output logic [31:0]              result_q,
  output logic                     overflow_flag,
  output logic                     negative_flag,
  output logic                     repeat_block_active_flag,
  output logic                     irq
);
  import aos_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]       acc_r,     acc_nxt;
  logic              ovf_r,     ovf_nxt;
  logic              neg_r,     neg_nxt;
  logic              ovm_r,     ovm_nxt;
  logic [OVC_W-1:0]  ovc_r,     ovc_nxt;
  logic [MPC_W-1:0]  mpc_r,     mpc_nxt;
  logic              loop_r,    loop_nxt;
  logic [IRQ_W-1:0]  ist_r,     ist_nxt;
  logic [IRQ_W-1:0]  imask_r,   imask_nxt;
  logic              irq_r,     irq_nxt;

  logic [31:0]       add_sum;
  logic              add_pos;
  logic              add_neg;
  logic [31:0]       sh_res;
  logic [31:0]       sat_sum;
  logic [31:0]       ovc_ext;

  aos_sat_calc #(.W(DATA_W)) u_add (
    .a       (acc_r),
    .b       (cmd.operand),
    .sub     (cmd.op == AOS_OP_SUB),
    .sum     (add_sum),
    .ovf_pos (add_pos),
    .ovf_neg (add_neg)
  );

  // The counted wraps are folded back in units of two to the thirty-two,
  // so the net correction only decides which extreme, if any, applies.
  assign ovc_ext = {{(32-OVC_W){ovc_r[OVC_W-1]}}, ovc_r};

  aos_sat_calc #(.W(DATA_W)) u_satadd (
    .a       (acc_r),
    .b       (32'h00000000),
    .sub     (1'b0),
    .sum     (sat_sum),
    .ovf_pos (),
    .ovf_neg ()
  );

  aos_shifter #(.W(DATA_W), .CW(SHCNT_W)) u_sh (
    .value  (acc_r),
    .count  (mpc_r[SHCNT_W-1:0]),
    .kind   (cmd.shift),
    .result (sh_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state.
  logic              aw_hold_r, aw_hold_nxt;
  logic              w_hold_r,  w_hold_nxt;
  logic [7:0]        awaddr_r,  awaddr_nxt;
  logic [31:0]       wdata_r,   wdata_nxt;
  logic [3:0]        wstrb_r,   wstrb_nxt;
  logic              bvalid_r,  bvalid_nxt;
  logic [1:0]        bresp_r,   bresp_nxt;
  logic              rvalid_r,  rvalid_nxt;
  logic [1:0]        rresp_r,   rresp_nxt;
  logic [31:0]       rdata_r,   rdata_nxt;
  logic              wr_fire;
  logic              rd_fire;
  logic [31:0]       st0_view;
  logic [31:0]       st1_view;
  logic [31:0]       wmerge;
  logic [31:0]       wold;

  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_comb begin
    st0_view = 32'h00000000;
    st0_view[ST0_OVF_BIT] = ovf_r;
    st0_view[ST0_NEG_BIT] = neg_r;
    st0_view[ST0_OVM_BIT] = ovm_r;
    st0_view[ST0_OVC_LSB +: OVC_W] = ovc_r;
    st1_view = 32'h00000000;
    st1_view[ST1_LOOP_BIT] = loop_r;
  end

  always_comb begin
    if (awaddr_r == OFS_ST0) begin
      wold = st0_view;
    end else if (awaddr_r == OFS_RESULT) begin
      wold = acc_r;
    end else if (awaddr_r == OFS_MPC) begin
      wold = {16'h0000, mpc_r};
    end else if (awaddr_r == OFS_IRQ_MASK) begin
      wold = {29'h00000000, imask_r};
    end else begin
      wold = 32'h00000000;
    end
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = wstrb_r[i] ? wdata_r[i*8 +: 8] : wold[i*8 +: 8];
    end
  end

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      if (awaddr_r == OFS_ST0 || awaddr_r == OFS_RESULT || awaddr_r == OFS_MPC ||
          awaddr_r == OFS_IRQ_MASK || awaddr_r == OFS_ST1 || awaddr_r == OFS_IRQ_ST) begin
        bresp_nxt = RESP_OKAY;
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      if (s_axi_araddr == OFS_ST0) begin
        rdata_nxt = st0_view;
      end else if (s_axi_araddr == OFS_ST1) begin
        rdata_nxt = st1_view;
      end else if (s_axi_araddr == OFS_RESULT) begin
        rdata_nxt = acc_r;
      end else if (s_axi_araddr == OFS_MPC) begin
        rdata_nxt = {16'h0000, mpc_r};
      end else if (s_axi_araddr == OFS_IRQ_ST) begin
        rdata_nxt = {29'h00000000, ist_r};
      end else if (s_axi_araddr == OFS_IRQ_MASK) begin
        rdata_nxt = {29'h00000000, imask_r};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath and flags. A bus write to a register and a core update in the
  // same cycle resolve in favour of the core, the sticky flag included.
  logic ev_pos;
  logic ev_neg;
  logic ev_sat;

  always_comb begin
    acc_nxt   = acc_r;
    ovf_nxt   = ovf_r;
    neg_nxt   = neg_r;
    ovm_nxt   = ovm_r;
    ovc_nxt   = ovc_r;
    mpc_nxt   = mpc_r;
    imask_nxt = imask_r;
    ev_pos    = 1'b0;
    ev_neg    = 1'b0;
    ev_sat    = 1'b0;

    // Software side first, so that hardware events below win.
    if (wr_fire && awaddr_r == OFS_ST0) begin
      ovf_nxt = wmerge[ST0_OVF_BIT];
      neg_nxt = wmerge[ST0_NEG_BIT];
      ovm_nxt = wmerge[ST0_OVM_BIT];
      ovc_nxt = wmerge[ST0_OVC_LSB +: OVC_W];
    end
    if (wr_fire && awaddr_r == OFS_RESULT) begin
      acc_nxt = wmerge;
    end
    if (wr_fire && awaddr_r == OFS_MPC) begin
      mpc_nxt = wmerge[MPC_W-1:0];
    end
    if (wr_fire && awaddr_r == OFS_IRQ_MASK) begin
      imask_nxt = wmerge[IRQ_W-1:0];
    end
    if (ctl.cond_branch) begin
      ovf_nxt = 1'b0;
    end
    if (ctl.mpc_load) begin
      mpc_nxt = ctl.mpc_data;
    end

    if (cmd.valid) begin
      case (cmd.op)
        AOS_OP_ADD, AOS_OP_SUB: begin
          ev_pos = add_pos;
          ev_neg = add_neg;
          if ((add_pos || add_neg) && ovm_r) begin
            acc_nxt = add_pos ? SAT_POS : SAT_NEG;
          end else begin
            acc_nxt = add_sum;
          end
          if ((add_pos || add_neg) && !ovm_r) begin
            // Counting is suspended while saturation mode is on.
            if (add_pos) begin
              ovc_nxt = ovc_r + 6'h01;
            end else begin
              ovc_nxt = ovc_r - 6'h01;
            end
          end
          if (add_pos || add_neg) begin
            ovf_nxt = 1'b1;
          end
          // Without overflow the flag keeps whatever value it had.
          neg_nxt = acc_nxt[DATA_W-1];
        end
        AOS_OP_SHIFT: begin
          acc_nxt = sh_res;
          neg_nxt = sh_res[DATA_W-1];
        end
        AOS_OP_SAT: begin
          ev_sat = 1'b1;
          if (!ovc_ext[31] && ovc_r != 6'h00) begin
            acc_nxt = SAT_POS;
          end else if (ovc_ext[31]) begin
            acc_nxt = SAT_NEG;
          end else begin
            acc_nxt = sat_sum;
          end
          ovc_nxt = 6'h00;
          neg_nxt = acc_nxt[DATA_W-1];
        end
        AOS_OP_LOAD: begin
          acc_nxt = cmd.operand;
          neg_nxt = cmd.operand[DATA_W-1];
        end
        default: begin
          acc_nxt = acc_r;
        end
      endcase
    end
  end

  always_comb begin
    loop_nxt = ctl.loop_nz | ctl.loop_z;
    ist_nxt  = ist_r;
    if (rd_fire && s_axi_araddr == OFS_IRQ_ST) begin
      ist_nxt = {IRQ_W{1'b0}};
    end
    // Events set after the read clear, so a coincident event survives.
    if (ev_pos) ist_nxt[IRQ_OVF_POS] = 1'b1;
    if (ev_neg) ist_nxt[IRQ_OVF_NEG] = 1'b1;
    if (ev_sat) ist_nxt[IRQ_SAT_DONE] = 1'b1;
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r     <= 32'h00000000;
      ovf_r     <= 1'b0;
      neg_r     <= 1'b0;
      ovm_r     <= 1'b0;
      ovc_r     <= 6'h00;
      mpc_r     <= 16'h0000;
      loop_r    <= 1'b0;
      ist_r     <= 3'h0;
      imask_r   <= 3'h0;
      irq_r     <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h00000000;
    end else begin
      acc_r     <= acc_nxt;
      ovf_r     <= ovf_nxt;
      neg_r     <= neg_nxt;
      ovm_r     <= ovm_nxt;
      ovc_r     <= ovc_nxt;
      mpc_r     <= mpc_nxt;
      loop_r    <= loop_nxt;
      ist_r     <= ist_nxt;
      imask_r   <= imask_nxt;
      irq_r     <= irq_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // Ready terms are registers' inverse; one write and one read in flight.
  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready  = ~w_hold_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign result_q      = acc_r;
  assign overflow_flag = ovf_r;
  assign negative_flag = neg_r;
  assign repeat_block_active_flag = loop_r;
  assign irq           = irq_r;
endmodule

// [bench/aos_core_model.sv]
`timescale 1ns/1ps
module aos_core_model (
  // Clock
  input  wire logic         aclk,
  // Execute stage outputs
  output aos_pkg::aos_cmd_s cmd,
  output aos_pkg::aos_ctl_s ctl
);
  import aos_pkg::*;
  initial begin
    cmd = '0;
    ctl = '0;
  end
  // A quiet cycle follows each pulse, so the caller sees settled results.
  task automatic exec(input aos_op_e op, input logic [31:0] v,
                      input aos_shift_e k = AOS_SH_ARITH_R);
    cmd <= '{1'b1, op, k, v};
    @(posedge aclk);
    cmd <= '0;
    @(posedge aclk);
  endtask
  task automatic pulse(input logic br, input logic ld, input logic [15:0] d);
    ctl.cond_branch <= br;
    ctl.mpc_load <= ld;
    ctl.mpc_data <= d;
    @(posedge aclk);
    ctl.cond_branch <= 1'b0;
    ctl.mpc_load <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic loop(input logic nz, input logic z);
    ctl.loop_nz <= nz;
    ctl.loop_z <= z;
    repeat (2) @(posedge aclk);
  endtask
endmodule

// [bench/aos_top_chk.sv]
`timescale 1ns/1ps
module aos_top_chk (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Core side
  input wire aos_pkg::aos_cmd_s cmd,
  input wire aos_pkg::aos_ctl_s ctl,
  // Bus responses
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  // Status
  input wire logic [31:0]       result_q,
  input wire logic              overflow_flag,
  input wire logic              negative_flag,
  input wire logic              repeat_block_active_flag
);
  import aos_pkg::*;
  logic [31:0] sum_w;
  logic        ovp_w;
  assign sum_w = result_q + cmd.operand;
  assign ovp_w = !result_q[31] && !cmd.operand[31] && sum_w[31];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_add;
    cmd.valid && cmd.op == AOS_OP_ADD;
  endsequence
  sequence s_add_ovf;
    s_add ##0 ovp_w;
  endsequence
  a_ovf_set: assert property (s_add_ovf |=> overflow_flag)
    else $error("overflow flag not set");
  a_ovf_kept: assert property (overflow_flag && !ctl.cond_branch |=>
    overflow_flag || s_axi_bvalid) else $error("overflow flag dropped");
  a_sat_wrap: assert property (s_add_ovf |=>
    result_q == SAT_POS || result_q == $past(sum_w)) else $error("bad overflow result");
  // Mixed signs can never overflow, so the plain sum must appear.
  a_add_plain: assert property (s_add ##0 (result_q[31] != cmd.operand[31]) |=>
    result_q == $past(sum_w)) else $error("bad sum");
  a_neg_msb: assert property (cmd.valid && cmd.op inside {AOS_OP_ADD, AOS_OP_SUB,
    AOS_OP_SHIFT, AOS_OP_LOAD} |=> negative_flag == result_q[31]) else $error("bad sign");
  a_loop_set: assert property (ctl.loop_nz || ctl.loop_z |=>
    repeat_block_active_flag) else $error("loop flag low");
  a_loop_clr: assert property (!ctl.loop_nz && !ctl.loop_z |=>
    !repeat_block_active_flag) else $error("loop flag high");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
endmodule

// [bench/accumulator_overflow_status_tb.sv]
`timescale 1ns/1ps
module accumulator_overflow_status_tb;
  import aos_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  aos_cmd_s    cmd;
  aos_ctl_s    ctl;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, result_q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        overflow_flag, negative_flag, repeat_block_active_flag, irq;
  int          n_errors = 0, checks = 0, cyc = 0;
  localparam aos_shift_e  SH_K[4] = '{AOS_SH_LOGIC_L, AOS_SH_LOGIC_R, AOS_SH_ARITH_R,
                                      AOS_SH_RESULT_R};
  localparam logic [31:0] SH_V[4] = '{32'h00000001, 32'h80000000, 32'h80000000,
                                      32'h80000000};
  localparam logic [31:0] SH_E[4] = '{32'h00000008, 32'h10000000, 32'hF0000000,
                                      32'hF0000000};
  aos_top u_aos_top (
    .aclk(aclk), .aresetn(aresetn), .cmd(cmd), .ctl(ctl),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .result_q(result_q), .overflow_flag(overflow_flag),
    .negative_flag(negative_flag), .repeat_block_active_flag(repeat_block_active_flag),
    .irq(irq)
  );
  aos_core_model u_aos_core_model (.aclk(aclk), .cmd(cmd), .ctl(ctl));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(r, RESP_OKAY);
    chk(d, e);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_count();
    u_aos_core_model.exec(AOS_OP_LOAD, 32'h7FFFFFFF);
    u_aos_core_model.exec(AOS_OP_ADD, 32'h00000001);
    chk(result_q, 32'h80000000);
    chk(overflow_flag, 1'b1);
    chk(negative_flag, 1'b1);
    rd_chk(OFS_ST0, 32'h00000103);
    u_aos_core_model.exec(AOS_OP_ADD, 32'h00000001);
    chk(overflow_flag, 1'b1);
    u_aos_core_model.pulse(1'b1, 1'b0, 16'h0000);
    chk(overflow_flag, 1'b0);
    u_aos_core_model.exec(AOS_OP_SUB, 32'h00000002);
    rd_chk(OFS_ST0, 32'h00000001);
    u_aos_core_model.exec(AOS_OP_ADD, 32'h00000001);
    u_aos_core_model.exec(AOS_OP_SAT, 32'h00000000);
    chk(result_q, 32'h7FFFFFFF);
    u_aos_core_model.exec(AOS_OP_LOAD, 32'h80000000);
    u_aos_core_model.exec(AOS_OP_SUB, 32'h00000001);
    rd_chk(OFS_ST0, 32'h00003F01);
    u_aos_core_model.exec(AOS_OP_SAT, 32'h00000000);
    chk(result_q, 32'h80000000);
    rd_chk(OFS_ST0, 32'h00000003);
    axw(OFS_ST0, 32'h00000000);
    chk(overflow_flag, 1'b0);
  endtask
  task automatic t_mode();
    axw(OFS_ST0, 32'h00000004);
    u_aos_core_model.exec(AOS_OP_LOAD, 32'h7FFFFFFF);
    u_aos_core_model.exec(AOS_OP_ADD, 32'h00000005);
    chk(result_q, SAT_POS);
    rd_chk(OFS_ST0, 32'h00000005);
    u_aos_core_model.exec(AOS_OP_LOAD, 32'h80000000);
    u_aos_core_model.exec(AOS_OP_SUB, 32'h00000001);
    chk(result_q, 32'h80000000);
    rd_chk(OFS_ST0, 32'h00000007);
    axw(OFS_ST0, 32'h00000000);
  endtask
  // Upper bits of the count source are set to show that only the low nibble counts.
  task automatic t_shift();
    u_aos_core_model.pulse(1'b0, 1'b1, 16'hFFF3);
    for (int i = 0; i < 4; i++) begin
      u_aos_core_model.exec(AOS_OP_LOAD, SH_V[i]);
      u_aos_core_model.exec(AOS_OP_SHIFT, 32'h00000000, SH_K[i]);
      chk(result_q, SH_E[i]);
    end
  endtask
  task automatic t_loop();
    u_aos_core_model.loop(1'b1, 1'b0);
    chk(repeat_block_active_flag, 1'b1);
    rd_chk(OFS_ST1, 32'h00000001);
    u_aos_core_model.loop(1'b0, 1'b1);
    chk(repeat_block_active_flag, 1'b1);
    u_aos_core_model.loop(1'b0, 1'b0);
    chk(repeat_block_active_flag, 1'b0);
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0]  r;
    axr(OFS_IRQ_ST, d, r);
    axw(OFS_IRQ_MASK, 32'h00000001);
    u_aos_core_model.exec(AOS_OP_LOAD, 32'h7FFFFFFF);
    u_aos_core_model.exec(AOS_OP_ADD, 32'h00000001);
    chk(irq, 1'b1);
    rd_chk(OFS_IRQ_ST, 32'h00000001);
    chk(irq, 1'b0);
    axw(OFS_IRQ_MASK, 32'h00000000);
    u_aos_core_model.exec(AOS_OP_LOAD, 32'h7FFFFFFF);
    u_aos_core_model.exec(AOS_OP_ADD, 32'h00000001);
    chk(irq, 1'b0);
    rd_chk(OFS_IRQ_ST, 32'h00000001);
    axr(8'h40, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h00000000);
  endtask
  ////////////////////////////////////////////////////////////////////
  // The ceiling sits far above the hundred or so cycles the scenarios need.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_count();
    t_mode();
    t_shift();
    t_loop();
    t_irq();
    stop_test();
  end
endmodule
bind aos_top aos_top_chk u_aos_top_chk (
  .aclk(aclk), .aresetn(aresetn), .cmd(cmd), .ctl(ctl),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .result_q(result_q), .overflow_flag(overflow_flag), .negative_flag(negative_flag),
  .repeat_block_active_flag(repeat_block_active_flag)
);
